// [verilog/art_pkg.sv]
// constants for the auto-reload / capture timer and its register map
// assumes a classic wishbone slave with 32-bit data, registers in byte 0

package art_pkg;

   localparam int unsigned ART_ADR_W = 8;

   // byte addresses of the word registers
   localparam logic [7:0] ART_A_CTRL   = 8'h00;
   localparam logic [7:0] ART_A_CNT_LO = 8'h04;
   localparam logic [7:0] ART_A_CNT_HI = 8'h08;
   localparam logic [7:0] ART_A_RL_LO  = 8'h0C;
   localparam logic [7:0] ART_A_RL_HI  = 8'h10;
   localparam logic [7:0] ART_A_CKSEL  = 8'h14;
   localparam logic [7:0] ART_A_INTEN  = 8'h18;

   // timer_control_reg fields
   localparam int unsigned ART_B_HOVF  = 7;
   localparam int unsigned ART_B_LOVF  = 6;
   localparam int unsigned ART_B_LIEN  = 5;
   localparam int unsigned ART_B_CAPEN = 4;
   localparam int unsigned ART_B_SPLIT = 3;
   localparam int unsigned ART_B_RUN   = 2;
   localparam int unsigned ART_B_XSEL1 = 1;
   // clock_control_reg fields, then the interrupt enable register field
   localparam int unsigned ART_B_LSYS  = 0;
   localparam int unsigned ART_B_HSYS  = 1;
   localparam int unsigned ART_B_TIE   = 0;

   localparam logic [7:0]  ART_CTRL_RST = 8'h00;
   localparam logic [15:0] ART_CNT_RST  = 16'h0000;
   localparam logic [15:0] ART_RL_RST   = 16'h0000;
   localparam logic [7:0]  ART_BYTE_MAX = 8'hFF;
   localparam logic [15:0] ART_WORD_MAX = 16'hFFFF;

   // external clock select encodings
   localparam logic [1:0] ART_X_DIV12 = 2'h0;
   localparam logic [1:0] ART_X_OSC8  = 2'h1;
   localparam logic [1:0] ART_X_RSVD  = 2'h2;
   localparam logic [1:0] ART_X_CMP   = 2'h3;

   localparam int unsigned ART_SYS_DIV = 12;
   localparam int unsigned ART_OSC_DIV = 8;

endpackage : art_pkg

// [verilog/art_sync.sv]
// three-stage synchroniser for one asynchronous input pin
// assumes the pin is slow compared with clk_i
`timescale 1ns/100ps

module art_sync
   import art_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      rise_o
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         level_o <= 1'b0;
         rise_o  <= 1'b0;
      end
      else
      begin
         s1_q   <= pin_i;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         // a change counts only once two stages agree
         rise_o <= (s2_q == s3_q) && s3_q && !level_o;
         if (s2_q == s3_q)
            level_o <= s3_q;
      end
   end

endmodule : art_sync

// [verilog/art_timer.sv]
// auto-reload / capture timer with a classic wishbone register slave
// assumes oscillator and comparator pins are asynchronous to clk_i
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/100ps

module art_timer
   import art_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ART_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 osc_clk_i,
   input  wire logic                 cmp0_i,
   output logic                      timer_irq_o
);

   logic [7:0]  ctrl_q;
   logic [7:0]  ctrl_d;
   logic [15:0] cnt_q;
   logic [15:0] rl_q;
   logic [1:0]  cksel_q;
   logic        tie_q;
   logic [3:0]  div12_q;
   logic [2:0]  osc8_q;
   logic        tick_div12;
   logic        tick_osc8;
   logic        osc_rise;
   logic        cmp_rise;
   logic        tick_lo;
   logic        tick_hi;
   logic        mode16;
   logic        cap_on;
   logic        cap_evt;
   logic        lo_wrap;
   logic        hi_wrap;
   logic        full_wrap;
   logic        set_h;
   logic        set_l;
   logic        bus_wr;
   logic        wr_ctrl;
   logic        wr_clo;
   logic        wr_chi;
   logic [31:0] rd_d;

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after the request, write on ack edge

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                    && wb_sel_i[0];
   assign wr_ctrl = bus_wr && (wb_adr_i == ART_A_CTRL);
   assign wr_clo  = bus_wr && (wb_adr_i == ART_A_CNT_LO);
   assign wr_chi  = bus_wr && (wb_adr_i == ART_A_CNT_HI);

   always_comb
   begin
      rd_d = 32'h0000_0000;
      case (wb_adr_i)
         ART_A_CTRL:   rd_d[7:0] = ctrl_q;
         ART_A_CNT_LO: rd_d[7:0] = cnt_q[7:0];
         ART_A_CNT_HI: rd_d[7:0] = cnt_q[15:8];
         ART_A_RL_LO:  rd_d[7:0] = rl_q[7:0];
         ART_A_RL_HI:  rd_d[7:0] = rl_q[15:8];
         ART_A_CKSEL:  rd_d[1:0] = cksel_q;
         ART_A_INTEN:  rd_d[0]   = tie_q;
         default:      rd_d      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
         wb_dat_o <= rd_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // clock sources

   art_sync u_osc_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (osc_clk_i),
      .level_o (),
      .rise_o  (osc_rise)
   );

   art_sync u_cmp_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (cmp0_i),
      .level_o (),
      .rise_o  (cmp_rise)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         div12_q <= 4'h0;
      else if (div12_q == 4'(ART_SYS_DIV - 1))
         div12_q <= 4'h0;
      else
         div12_q <= div12_q + 4'h1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         osc8_q <= 3'h0;
      else if (osc_rise)
         osc8_q <= osc8_q + 3'h1;
   end

   assign tick_div12 = (div12_q == 4'(ART_SYS_DIV - 1));
   assign tick_osc8  = osc_rise && (osc8_q == 3'(ART_OSC_DIV - 1));

   function automatic logic pick_tick(input logic       sys,
                                      input logic [1:0] xs,
                                      input logic       d12,
                                      input logic       o8,
                                      input logic       cmp);
      logic t;
      t = 1'b0;
      if (sys)
         t = 1'b1;
      else
         case (xs)
            ART_X_DIV12: t = d12;
            ART_X_OSC8:  t = o8;
            ART_X_CMP:   t = cmp;
            default:     t = 1'b0;
         endcase
      return t;
   endfunction : pick_tick

   assign tick_lo = pick_tick(cksel_q[ART_B_LSYS], ctrl_q[ART_B_XSEL1:0],
                              tick_div12, tick_osc8, cmp_rise);
   assign tick_hi = pick_tick(cksel_q[ART_B_HSYS], ctrl_q[ART_B_XSEL1:0],
                              tick_div12, tick_osc8, cmp_rise);

   ////////////////////////////////////////////////////////////////////////
   // counting, reload and capture

   // capture forces 16-bit counting even if split was left set
   assign cap_on  = ctrl_q[ART_B_CAPEN];
   assign mode16  = cap_on || !ctrl_q[ART_B_SPLIT];
   assign cap_evt = cap_on && (ctrl_q[ART_B_XSEL1] ? cmp_rise
                                                   : tick_osc8);

   always_comb
   begin
      full_wrap = 1'b0;
      lo_wrap   = 1'b0;
      hi_wrap   = 1'b0;
      if (mode16)
      begin
         full_wrap = ctrl_q[ART_B_RUN] && tick_lo
                     && (cnt_q == ART_WORD_MAX);
         lo_wrap   = ctrl_q[ART_B_RUN] && tick_lo
                     && (cnt_q[7:0] == ART_BYTE_MAX);
      end
      else
      begin
         lo_wrap = tick_lo && (cnt_q[7:0] == ART_BYTE_MAX);
         hi_wrap = ctrl_q[ART_B_RUN] && tick_hi
                   && (cnt_q[15:8] == ART_BYTE_MAX);
      end
      set_h = (full_wrap && !cap_on) || hi_wrap || cap_evt;
      set_l = lo_wrap;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_q <= ART_CNT_RST;
      else
      begin
         if (mode16)
         begin
            if (ctrl_q[ART_B_RUN] && tick_lo)
               cnt_q <= (full_wrap && !cap_on) ? rl_q
                                               : cnt_q + 16'h0001;
         end
         else
         begin
            if (tick_lo)
               cnt_q[7:0] <= lo_wrap ? rl_q[7:0]
                                     : cnt_q[7:0] + 8'h01;
            if (ctrl_q[ART_B_RUN] && tick_hi)
               cnt_q[15:8] <= hi_wrap ? rl_q[15:8]
                                      : cnt_q[15:8] + 8'h01;
         end
         if (wr_clo)
            cnt_q[7:0] <= wb_dat_i[7:0];
         if (wr_chi)
            cnt_q[15:8] <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rl_q <= ART_RL_RST;
      else if (cap_evt)
         rl_q <= cnt_q;
      else if (bus_wr && (wb_adr_i == ART_A_RL_LO))
         rl_q[7:0] <= wb_dat_i[7:0];
      else if (bus_wr && (wb_adr_i == ART_A_RL_HI))
         rl_q[15:8] <= wb_dat_i[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // control, flags and interrupt request

   always_comb
   begin
      ctrl_d = wr_ctrl ? wb_dat_i[7:0] : ctrl_q;
      // a hardware set wins over a software clear in the same cycle
      ctrl_d[ART_B_HOVF] = ctrl_d[ART_B_HOVF] || set_h;
      ctrl_d[ART_B_LOVF] = ctrl_d[ART_B_LOVF] || set_l;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_q <= ART_CTRL_RST;
      else
         ctrl_q <= ctrl_d;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cksel_q <= 2'h0;
         tie_q   <= 1'b0;
      end
      else
      begin
         if (bus_wr && (wb_adr_i == ART_A_CKSEL))
            cksel_q <= wb_dat_i[1:0];
         if (bus_wr && (wb_adr_i == ART_A_INTEN))
            tie_q <= wb_dat_i[ART_B_TIE];
      end
   end

   // while TIE is set the request follows the high flag, and the low flag only while LIEN is set too; software finds the source itself
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         timer_irq_o <= 1'b0;
      else
         timer_irq_o <= tie_q && (ctrl_q[ART_B_HOVF]
            || (ctrl_q[ART_B_LIEN] && ctrl_q[ART_B_LOVF]));
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic cnt_wr;
   assign cnt_wr = wr_clo || wr_chi;

   property p_wrap16;
      mode16 && !cap_on && full_wrap && !cnt_wr
      |=> cnt_q == $past(rl_q) && ctrl_q[ART_B_HOVF];
   endproperty
   a_wrap16: assert property (p_wrap16)
      else $error("16-bit wrap did not reload or flag");
   property p_irq_h;
      tie_q && ctrl_q[ART_B_HOVF] |=> timer_irq_o;
   endproperty
   a_irq_h: assert property (p_irq_h)
      else $error("high flag did not request interrupt");
   property p_irq_l;
      tie_q && ctrl_q[ART_B_LIEN] && ctrl_q[ART_B_LOVF] |=> timer_irq_o;
   endproperty
   a_irq_l: assert property (p_irq_l)
      else $error("low flag did not request interrupt");
   property p_no_irq;
      !tie_q ##1 !tie_q |-> !timer_irq_o;
   endproperty
   a_no_irq: assert property (p_no_irq)
      else $error("interrupt while timer interrupts disabled");
   property p_split_lo;
      !mode16 && lo_wrap && !cnt_wr
      |=> cnt_q[7:0] == $past(rl_q[7:0]) && ctrl_q[ART_B_LOVF];
   endproperty
   a_split_lo: assert property (p_split_lo)
      else $error("split low wrap did not reload or flag");
   property p_split_hold;
      !mode16 && !ctrl_q[ART_B_RUN] && !cnt_wr
      |=> $stable(cnt_q[15:8]);
   endproperty
   a_split_hold: assert property (p_split_hold)
      else $error("high byte moved while stopped");
   property p_sticky;
      ctrl_q[ART_B_HOVF] && !wr_ctrl |=> ctrl_q[ART_B_HOVF];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("high flag cleared by hardware");
   property p_rsvd;
      !cksel_q[ART_B_LSYS] && ctrl_q[ART_B_XSEL1:0] == ART_X_RSVD
      |-> !tick_lo;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved select produced a tick");
   property p_hold16;
      mode16 && !ctrl_q[ART_B_RUN] && !cnt_wr |=> $stable(cnt_q);
   endproperty
   a_hold16: assert property (p_hold16)
      else $error("16-bit counter moved while stopped");
   property p_capture;
      cap_evt |=> rl_q == $past(cnt_q) && ctrl_q[ART_B_HOVF];
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture did not copy counter");

   c_capture: cover property (cap_evt ##[1:1000] cap_evt);
   c_split:   cover property (!mode16 && hi_wrap);
   c_wrap16:  cover property (full_wrap && !cap_on);

endmodule : art_timer

// [sim/art_src.sv]
// model of the oscillator pin and the comparator output feeding the timer
// assumes the bench calls its tasks; both pins rest low between bursts
`timescale 1ns/100ps

module art_src
(
   output logic osc_o,
   output logic cmp_o
);
   initial
   begin
      osc_o = 1'b0;
      cmp_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // periods unrelated to the 50 ns clock so the edges drift across it;
   // both far slower than the timer clock
   task osc_cycles(input int n);
      repeat (n)
      begin
         #157 osc_o = 1'b1;
         #157 osc_o = 1'b0;
      end
   endtask : osc_cycles

   task cmp_edges(input int n);
      repeat (n)
      begin
         #373 cmp_o = 1'b1;
         #373 cmp_o = 1'b0;
      end
   endtask : cmp_edges
endmodule : art_src

// [sim/art_timer_tb.sv]
// self-checking bench for the auto-reload / capture timer
// assumes the source model drives the oscillator and comparator pins
`timescale 1ns/100ps

module art_timer_tb
   import art_pkg::*;
;
   logic        clk_i, rst_i, cyc, stb, we;
   logic [7:0]  adr;
   logic [31:0] dat, rdat, q, q2;
   logic        ack, irq, osc, cmp;
   int          err_total, num_checks;

   art_src i_src (.osc_o(osc), .cmp_o(cmp));

   art_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_clk_i(osc),
      .cmp0_i(cmp), .timer_irq_o(irq));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task rng(input string nm, input logic [7:0] lo, input logic [7:0] hi,
            input logic [31:0] g);
      chk(nm, 32'h1, {31'h0, (g >= lo && g <= hi)});
   endtask : rng

   // classic single cycle; waits for ack, then one idle cycle
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50)
         chk("ack", 32'h1, 32'h0);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask : wr

   task rd(input logic [7:0] a);
      wb(1'b0, a, 8'h00);
   endtask : rd

   task wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_clk

   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(ART_A_CTRL);
      chk("ctrl rst", 32'h0, q);
      rd(ART_A_RL_HI);
      chk("reload rst", 32'h0, q);
      wr(8'h1C, 8'hA5);
      rd(8'h1C);
      chk("unmapped", 32'h0, q);
   endtask : t_reset

   task t_reload16;
      wr(ART_A_CKSEL, 8'h01);
      wr(ART_A_RL_LO, 8'hF0);
      wr(ART_A_RL_HI, 8'hFF);
      wr(ART_A_CNT_LO, 8'hFE);
      wr(ART_A_CNT_HI, 8'hFF);
      wr(ART_A_CTRL, 8'h04);
      wait_clk(4);
      rd(ART_A_CTRL);
      chk("hflag set", 32'h80, q & 32'h80);
      wr(ART_A_CTRL, 8'h80);
      rd(ART_A_CNT_HI);
      chk("cnt hi reload", 32'hFF, q);
      rd(ART_A_CNT_LO);
      rng("cnt lo reload", 8'hF0, 8'hFE, q);
      q2 = q;
      wait_clk(20);
      rd(ART_A_CNT_LO);
      chk("held", q2, q);
      rd(ART_A_CTRL);
      chk("hflag kept", 32'h80, q & 32'h80);
      wr(ART_A_INTEN, 8'h01);
      wait_clk(3);
      chk("irq full", 32'h1, {31'h0, irq});
      wr(ART_A_CTRL, 8'h00);
      wait_clk(3);
      chk("irq clear", 32'h0, {31'h0, irq});
   endtask : t_reload16

   task t_lowint;
      wr(ART_A_CNT_LO, 8'hF0);
      wr(ART_A_CNT_HI, 8'h00);
      wr(ART_A_CTRL, 8'h24);
      wait_clk(30);
      chk("irq low", 32'h1, {31'h0, irq});
      rd(ART_A_CTRL);
      chk("low flag", 32'h64, q);
      wr(ART_A_CTRL, 8'h00);
   endtask : t_lowint

   task t_split;
      wr(ART_A_CKSEL, 8'h03);
      wr(ART_A_RL_LO, 8'hF8);
      wr(ART_A_RL_HI, 8'hE0);
      wr(ART_A_CNT_HI, 8'h55);
      wr(ART_A_CNT_LO, 8'hFE);
      wr(ART_A_CTRL, 8'h08);
      wait_clk(20);
      chk("irq no len", 32'h0, {31'h0, irq});
      rd(ART_A_CTRL);
      chk("split flags", 32'h48, q);
      rd(ART_A_CNT_HI);
      chk("hi gated", 32'h55, q);
      rd(ART_A_CNT_LO);
      rng("lo reload", 8'hF8, 8'hFF, q);
      wr(ART_A_CNT_HI, 8'hFE);
      wr(ART_A_CTRL, 8'h0C);
      wait_clk(6);
      rd(ART_A_CTRL);
      chk("hi flag", 32'h80, q & 32'h80);
      chk("irq hi", 32'h1, {31'h0, irq});
      wr(ART_A_CTRL, 8'h08);
      rd(ART_A_CNT_HI);
      rng("hi reload", 8'hE0, 8'hF0, q);
      wr(ART_A_CTRL, 8'h28);
      wait_clk(10);
      chk("irq lo split", 32'h1, {31'h0, irq});
      rd(ART_A_CTRL);
      chk("lo source", 32'h40, q & 32'hC0);
      wr(ART_A_CTRL, 8'h00);
   endtask : t_split

   task t_sources;
      wr(ART_A_CKSEL, 8'h00);
      wr(ART_A_CNT_LO, 8'h00);
      wr(ART_A_CNT_HI, 8'h00);
      wr(ART_A_CTRL, 8'h04);
      wait_clk(120);
      wr(ART_A_CTRL, 8'h00);
      rd(ART_A_CNT_LO);
      rng("div12", 8'h09, 8'h0B, q);
      wr(ART_A_CNT_LO, 8'h00);
      wr(ART_A_CTRL, 8'h06);
      wait_clk(60);
      wr(ART_A_CTRL, 8'h00);
      rd(ART_A_CNT_LO);
      chk("reserved", 32'h0, q);
      wr(ART_A_CTRL, 8'h05);
      i_src.osc_cycles(16);
      wait_clk(10);
      wr(ART_A_CTRL, 8'h00);
      rd(ART_A_CNT_LO);
      chk("osc8", 32'h2, q);
      wr(ART_A_CNT_LO, 8'h00);
      wr(ART_A_CTRL, 8'h07);
      i_src.cmp_edges(5);
      wait_clk(10);
      wr(ART_A_CTRL, 8'h00);
      rd(ART_A_CNT_LO);
      chk("cmp", 32'h5, q);
   endtask : t_sources

   task t_capture;
      wr(ART_A_CKSEL, 8'h01);
      wr(ART_A_RL_LO, 8'h00);
      wr(ART_A_RL_HI, 8'h00);
      wr(ART_A_CTRL, 8'h14);
      wait_clk(20);
      rd(ART_A_CTRL);
      chk("no event", 32'h0, q & 32'h80);
      i_src.osc_cycles(8);
      wait_clk(10);
      rd(ART_A_CTRL);
      chk("osc capture", 32'h80, q & 32'h80);
      chk("irq capture", 32'h1, {31'h0, irq});
      rd(ART_A_RL_HI);
      q2 = q << 8;
      rd(ART_A_RL_LO);
      q2 = q2 | q;
      chk("captured", 32'h1, {31'h0, q2 != 0});
      wr(ART_A_CTRL, 8'h16);
      i_src.cmp_edges(1);
      wait_clk(10);
      rd(ART_A_CTRL);
      chk("cmp capture", 32'h80, q & 32'h80);
      rd(ART_A_RL_HI);
      chk("later", 32'h1, {31'h0, (q << 8) >= (q2 & 32'hFF00)});
      wr(ART_A_CTRL, 8'h00);
   endtask : t_capture

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      err_total  = 0;
      num_checks = 0;
      rst_i = 1'b1;
      cyc   = 1'b0;
      stb   = 1'b0;
      we    = 1'b0;
      adr   = 8'h00;
      dat   = 32'h0;
      wait_clk(12);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_reload16;
      t_lowint;
      t_split;
      t_sources;
      t_capture;
      end_of_test;
   end

   // the whole run needs about a thousand cycles
   initial
   begin
      wait_clk(40000);
      err_total++;
      end_of_test;
   end
endmodule : art_timer_tb
